// file: core/fsc_defines.svh
// Constants for the fp store/subtract/compare decoder.
// Assumes byte-wide opcode and modrm fields from the integer unit.
`ifndef FSC_DEFINES_SVH
`define FSC_DEFINES_SVH
// opcode bytes
`define FSC_OP_WAIT 8'h9B
`define FSC_OP_D8 8'hD8
`define FSC_OP_D9 8'hD9
`define FSC_OP_DA 8'hDA
`define FSC_OP_DB 8'hDB
`define FSC_OP_DC 8'hDC
`define FSC_OP_DD 8'hDD
`define FSC_OP_DE 8'hDE
`define FSC_OP_DF 8'hDF
// whole modrm bytes
`define FSC_MR_AX 8'hE0
`define FSC_MR_TST 8'hE4
`define FSC_MR_XAM 8'hE5
`define FSC_MR_XTR 8'hF4
`define FSC_MR_L2X 8'hF1
`define FSC_MR_L2XP1 8'hF9
`define FSC_MR_UCPP 8'hE9
// modrm fields
`define FSC_MOD_REG 2'h3
`define FSC_HI_1110 5'h1C
`define FSC_HI_1110_1 5'h1D
`define FSC_HI_1100_1 5'h19
`define FSC_REG_SI 3'h2
`define FSC_REG_SIP 3'h3
`define FSC_REG_SUB 3'h4
`define FSC_REG_SUBR 3'h5
`define FSC_REG_ENV 3'h6
`define FSC_REG_CW 3'h7
`define FSC_REG_LIP 3'h7
// clock counts
`define FSC_T_SI32_MIN 8'd8
`define FSC_T_SI32_MAX 8'd13
`define FSC_T_SI16_MIN 8'd7
`define FSC_T_SI16_MAX 8'd10
`define FSC_T_SI64_MIN 8'd10
`define FSC_T_SI64_MAX 8'd13
`define FSC_T_CW_W 8'd5
`define FSC_T_CW_N 8'd3
`define FSC_T_ENV_W_MIN 8'd14
`define FSC_T_ENV_W_MAX 8'd24
`define FSC_T_ENV_N_MIN 8'd12
`define FSC_T_ENV_N_MAX 8'd22
`define FSC_T_SW_W 8'd6
`define FSC_T_SW_N 8'd4
`define FSC_T_AX_W 8'd4
`define FSC_T_AX_N 8'd2
`define FSC_T_SUB_MIN 8'd4
`define FSC_T_SUB_MAX 8'd9
`define FSC_T_ISUB_MIN 8'd14
`define FSC_T_ISUB32_MAX 8'd29
`define FSC_T_ISUB16_MAX 8'd27
`define FSC_T_CMP 8'd4
`define FSC_T_WAIT 8'd2
`define FSC_T_XCH 8'd3
`define FSC_T_XTR_MIN 8'd11
`define FSC_T_XTR_MAX 8'd16
`define FSC_T_L2X_MIN 8'd145
`define FSC_T_L2X_MAX 8'd154
`define FSC_T_L2XP1_MIN 8'd131
`define FSC_T_L2XP1_MAX 8'd133
`define FSC_T_ONE 8'd1
`define FSC_T_SAT 8'hFF
`endif

// file: core/fsc_pkg.sv
// Types for the fp store/subtract/compare decoder.
// Assumes fsc_defines.svh for numeric constants.
`default_nettype none
package fsc_pkg;
   typedef enum logic [4:0] {
      FSC_NONE, FSC_STORE_INT, FSC_STORE_INT_POP, FSC_STORE_CW, FSC_STORE_ENV,
      FSC_STORE_SW, FSC_STORE_SW_AX, FSC_SUB, FSC_ISUB, FSC_TEST, FSC_UCOM,
      FSC_WAIT_IDLE, FSC_CLASSIFY, FSC_SWAP, FSC_SPLIT, FSC_LOG2, FSC_LOG2P1
   } fsc_op_t;
   typedef enum logic [2:0] {
      FSC_W_NONE, FSC_W_16, FSC_W_32, FSC_W_64
   } fsc_width_t;
   typedef enum logic [3:0] {
      FSC_S_IDLE = 4'h1, FSC_S_HOLD = 4'h2, FSC_S_EXEC = 4'h4, FSC_S_BAD = 4'h8
   } fsc_state_t;
   typedef struct packed {
      logic wait_prefix;
      logic [7:0] opcode;
      logic [7:0] modrm;
   } fsc_instr_t;
   // result = a - b for subtracts; a is the compared / stored operand otherwise
   typedef struct packed {
      fsc_op_t op;
      fsc_width_t width;
      logic a_mem;
      logic b_mem;
      logic [2:0] a_phys;
      logic [2:0] b_phys;
      logic [2:0] dst_phys;
      logic dst_mem;
      logic [1:0] pops;
      logic push;
   } fsc_ctrl_t;
endpackage
`default_nettype wire

// file: core/fsc_decoder.sv
// Decoder and sequencer for fp stores, subtracts, compares and related ops.
// Assumes instructions, busy and done come from logic on core_clk.
`include "fsc_defines.svh"
`default_nettype none
module fsc_decoder (
   // clock and reset
   input wire logic core_clk,
   input wire logic rstn,
   // instruction from integer unit
   input wire logic instr_valid,
   input wire fsc_pkg::fsc_instr_t instr,
   // execution unit status
   input wire logic unit_busy,
   input wire logic exec_done,
   // to integer unit and execution unit
   output logic ready_q,
   output logic start_q,
   output fsc_pkg::fsc_ctrl_t ctrl_q,
   output logic done_q,
   output logic bad_q,
   output logic [2:0] top_q
);
   import fsc_pkg::*;

   // ----------------------------------------
   // decode
   // ----------------------------------------
   fsc_ctrl_t dec;
   logic [7:0] tmin;
   logic [7:0] tmax;
   logic need_idle;
   logic known;
   logic [1:0] mo;
   logic [2:0] rg;
   logic [4:0] hi;
   logic [2:0] stn;
   logic [2:0] st1;
   logic is_reg;
   logic wp;

   always_comb begin
      mo = instr.modrm[7:6];
      rg = instr.modrm[5:3];
      hi = instr.modrm[7:3];
      is_reg = (mo == `FSC_MOD_REG);
      wp = instr.wait_prefix;
      // operand slots from the layout before execution
      stn = top_q + instr.modrm[2:0];
      st1 = top_q + 3'h1;
      dec = '0;
      dec.op = FSC_NONE;
      dec.width = FSC_W_NONE;
      dec.a_phys = top_q;
      dec.b_phys = top_q;
      dec.dst_phys = top_q;
      tmin = `FSC_T_ONE;
      tmax = `FSC_T_ONE;
      known = 1'b1;
      need_idle = wp;
      if (instr.opcode == `FSC_OP_WAIT) begin
         dec.op = FSC_WAIT_IDLE;
         need_idle = 1'b1;
         tmin = `FSC_T_WAIT;
         tmax = `FSC_T_WAIT;
      end else if (instr.opcode == `FSC_OP_DB && !is_reg && (rg == `FSC_REG_SI || rg == `FSC_REG_SIP)) begin
         dec.op = (rg == `FSC_REG_SI) ? FSC_STORE_INT : FSC_STORE_INT_POP;
         dec.width = FSC_W_32;
         dec.dst_mem = 1'b1;
         dec.pops = (rg == `FSC_REG_SIP) ? 2'h1 : 2'h0;
         tmin = `FSC_T_SI32_MIN;
         tmax = `FSC_T_SI32_MAX;
      end else if (instr.opcode == `FSC_OP_DF && instr.modrm == `FSC_MR_AX) begin
         dec.op = FSC_STORE_SW_AX;
         tmin = wp ? `FSC_T_AX_W : `FSC_T_AX_N;
         tmax = tmin;
      end else if (instr.opcode == `FSC_OP_DF && !is_reg
                   && (rg == `FSC_REG_SI || rg == `FSC_REG_SIP || rg == `FSC_REG_LIP)) begin
         dec.op = (rg == `FSC_REG_SI) ? FSC_STORE_INT : FSC_STORE_INT_POP;
         dec.dst_mem = 1'b1;
         dec.pops = (rg == `FSC_REG_SI) ? 2'h0 : 2'h1;
         dec.width = (rg == `FSC_REG_LIP) ? FSC_W_64 : FSC_W_16;
         tmin = (rg == `FSC_REG_LIP) ? `FSC_T_SI64_MIN : `FSC_T_SI16_MIN;
         tmax = (rg == `FSC_REG_LIP) ? `FSC_T_SI64_MAX : `FSC_T_SI16_MAX;
      end else if (instr.opcode == `FSC_OP_D9 && !is_reg && rg == `FSC_REG_CW) begin
         dec.op = FSC_STORE_CW;
         dec.dst_mem = 1'b1;
         dec.width = FSC_W_16;
         tmin = wp ? `FSC_T_CW_W : `FSC_T_CW_N;
         tmax = tmin;
      end else if (instr.opcode == `FSC_OP_D9 && !is_reg && rg == `FSC_REG_ENV) begin
         dec.op = FSC_STORE_ENV;
         dec.dst_mem = 1'b1;
         tmin = wp ? `FSC_T_ENV_W_MIN : `FSC_T_ENV_N_MIN;
         tmax = wp ? `FSC_T_ENV_W_MAX : `FSC_T_ENV_N_MAX;
      end else if (instr.opcode == `FSC_OP_DD && !is_reg && rg == `FSC_REG_CW) begin
         dec.op = FSC_STORE_SW;
         dec.dst_mem = 1'b1;
         dec.width = FSC_W_16;
         tmin = wp ? `FSC_T_SW_W : `FSC_T_SW_N;
         tmax = tmin;
      end else if ((instr.opcode == `FSC_OP_DC || instr.opcode == `FSC_OP_D8)
                   && (hi == `FSC_HI_1110 || hi == `FSC_HI_1110_1)) begin
         dec.op = FSC_SUB;
         tmin = `FSC_T_SUB_MIN;
         tmax = `FSC_T_SUB_MAX;
         // DC 1 n and D8 1 n write the entry; DC 0 n and D8 0 n write the top
         dec.dst_phys = instr.modrm[3] ? stn : top_q;
         // entry is minuend for DC 1 n and DC 0 n, top for the D8 forms
         dec.a_phys = (instr.opcode == `FSC_OP_DC) ? stn : top_q;
         dec.b_phys = (instr.opcode == `FSC_OP_DC) ? top_q : stn;
      end else if ((instr.opcode == `FSC_OP_DC || instr.opcode == `FSC_OP_D8)
                   && !is_reg && (rg == `FSC_REG_SUB || rg == `FSC_REG_SUBR)) begin
         dec.op = FSC_SUB;
         dec.width = (instr.opcode == `FSC_OP_DC) ? FSC_W_64 : FSC_W_32;
         dec.a_mem = (rg == `FSC_REG_SUBR);
         dec.b_mem = (rg == `FSC_REG_SUB);
         tmin = `FSC_T_SUB_MIN;
         tmax = `FSC_T_SUB_MAX;
      end else if (instr.opcode == `FSC_OP_DE && (hi == `FSC_HI_1110 || hi == `FSC_HI_1110_1)) begin
         dec.op = FSC_SUB;
         dec.dst_phys = stn;
         dec.pops = 2'h1;
         // 1 n: entry minus top, 0 n: top minus entry
         dec.a_phys = instr.modrm[3] ? stn : top_q;
         dec.b_phys = instr.modrm[3] ? top_q : stn;
         tmin = `FSC_T_SUB_MIN;
         tmax = `FSC_T_SUB_MAX;
      end else if ((instr.opcode == `FSC_OP_DA || instr.opcode == `FSC_OP_DE)
                   && !is_reg && (rg == `FSC_REG_SUB || rg == `FSC_REG_SUBR)) begin
         dec.op = FSC_ISUB;
         dec.width = (instr.opcode == `FSC_OP_DA) ? FSC_W_32 : FSC_W_16;
         dec.a_mem = (rg == `FSC_REG_SUBR);
         dec.b_mem = (rg == `FSC_REG_SUB);
         tmin = `FSC_T_ISUB_MIN;
         tmax = (instr.opcode == `FSC_OP_DA) ? `FSC_T_ISUB32_MAX : `FSC_T_ISUB16_MAX;
      end else if (instr.opcode == `FSC_OP_D9 && instr.modrm == `FSC_MR_TST) begin
         dec.op = FSC_TEST;
         tmin = `FSC_T_CMP;
         tmax = `FSC_T_CMP;
      end else if (instr.opcode == `FSC_OP_DD && (hi == `FSC_HI_1110 || hi == `FSC_HI_1110_1)) begin
         dec.op = FSC_UCOM;
         dec.b_phys = stn;
         dec.pops = {1'b0, instr.modrm[3]};
         tmin = `FSC_T_CMP;
         tmax = `FSC_T_CMP;
      end else if (instr.opcode == `FSC_OP_DA && instr.modrm == `FSC_MR_UCPP) begin
         dec.op = FSC_UCOM;
         dec.b_phys = st1;
         dec.pops = 2'h2;
         tmin = `FSC_T_CMP;
         tmax = `FSC_T_CMP;
      end else if (instr.opcode == `FSC_OP_D9 && instr.modrm == `FSC_MR_XAM) begin
         dec.op = FSC_CLASSIFY;
         tmin = `FSC_T_CMP;
         tmax = `FSC_T_CMP;
      end else if (instr.opcode == `FSC_OP_D9 && hi == `FSC_HI_1100_1) begin
         dec.op = FSC_SWAP;
         dec.b_phys = stn;
         dec.dst_phys = stn;
         tmin = `FSC_T_XCH;
         tmax = `FSC_T_XCH;
      end else if (instr.opcode == `FSC_OP_D9 && instr.modrm == `FSC_MR_XTR) begin
         dec.op = FSC_SPLIT;
         dec.push = 1'b1;
         tmin = `FSC_T_XTR_MIN;
         tmax = `FSC_T_XTR_MAX;
      end else if (instr.opcode == `FSC_OP_D9
                   && (instr.modrm == `FSC_MR_L2X || instr.modrm == `FSC_MR_L2XP1)) begin
         dec.op = (instr.modrm == `FSC_MR_L2X) ? FSC_LOG2 : FSC_LOG2P1;
         dec.b_phys = st1;
         dec.dst_phys = st1;
         dec.pops = 2'h1;
         tmin = (instr.modrm == `FSC_MR_L2X) ? `FSC_T_L2X_MIN : `FSC_T_L2XP1_MIN;
         tmax = (instr.modrm == `FSC_MR_L2X) ? `FSC_T_L2X_MAX : `FSC_T_L2XP1_MAX;
      end else begin
         known = 1'b0;
         need_idle = 1'b0;
      end
   end

   // ----------------------------------------
   // sequencer
   // ----------------------------------------
   fsc_state_t state_q;
   fsc_state_t state_d;
   logic [7:0] cnt_q;
   logic [7:0] min_q;
   logic [7:0] max_q;
   logic take;
   logic finish;

   assign take = (state_q == FSC_S_IDLE) && instr_valid;
   // fixed counts have min equal to max; ranged ones end on exec_done at or after min, or at max
   // a hold longer than max ends on the first exec cycle
   assign finish = (state_q == FSC_S_EXEC)
                   && ((cnt_q >= min_q && exec_done) || cnt_q >= max_q);

   always_comb begin
      state_d = state_q;
      case (state_q)
         FSC_S_IDLE: begin
            if (instr_valid && !known) begin
               state_d = FSC_S_BAD;
            end else if (instr_valid && need_idle && unit_busy) begin
               state_d = FSC_S_HOLD;
            end else if (instr_valid) begin
               state_d = FSC_S_EXEC;
            end
         end
         FSC_S_HOLD: begin
            if (!unit_busy) begin
               state_d = FSC_S_EXEC;
            end
         end
         FSC_S_EXEC: begin
            if (finish) begin
               state_d = FSC_S_IDLE;
            end
         end
         FSC_S_BAD: begin
            state_d = FSC_S_IDLE;
         end
         default: begin
            state_d = FSC_S_IDLE;
         end
      endcase
   end

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         state_q <= FSC_S_IDLE;
         ready_q <= 1'b1;
      end else begin
         state_q <= state_d;
         ready_q <= (state_d == FSC_S_IDLE);
      end
   end

   // cycle count, 1 in the first cycle after the instruction is taken
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         cnt_q <= 8'h00;
         min_q <= `FSC_T_ONE;
         max_q <= `FSC_T_ONE;
      end else if (take) begin
         cnt_q <= `FSC_T_ONE;
         min_q <= tmin;
         max_q <= tmax;
      end else if ((state_q == FSC_S_EXEC || state_q == FSC_S_HOLD) && cnt_q != `FSC_T_SAT) begin
         // saturates so a long hold cannot wrap back below max
         cnt_q <= cnt_q + `FSC_T_ONE;
      end
   end

   // ----------------------------------------
   // control outputs and stack pointer
   // ----------------------------------------
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         ctrl_q <= '0;
         start_q <= 1'b0;
      end else begin
         start_q <= take && known;
         if (take && known) begin
            ctrl_q <= dec;
         end
      end
   end

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         done_q <= 1'b0;
         bad_q <= 1'b0;
      end else begin
         done_q <= finish;
         bad_q <= take && !known;
      end
   end

   // pop increments, push decrements, applied as the instruction completes
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         top_q <= 3'h0;
      end else if (finish) begin
         top_q <= top_q + {1'b0, ctrl_q.pops} - {2'h0, ctrl_q.push};
      end
   end

endmodule
`default_nettype wire

// file: bench/fsc_decoder_checker.sv
// Timing and stack checks for fsc_decoder.
// Assumes it is bound to fsc_decoder and sees its ports only.
`default_nettype none
module fsc_decoder_checker (
   // clock and reset
   input wire logic core_clk,
   input wire logic rstn,
   // inputs
   input wire logic instr_valid,
   input wire fsc_pkg::fsc_instr_t instr,
   input wire logic unit_busy,
   input wire logic exec_done,
   // outputs
   input wire logic ready_q,
   input wire logic start_q,
   input wire fsc_pkg::fsc_ctrl_t ctrl_q,
   input wire logic done_q,
   input wire logic bad_q,
   input wire logic [2:0] top_q
);
   timeunit 1ns;
   timeprecision 1ns;
   import fsc_pkg::*;
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!rstn);
   logic tk;
   logic [7:0] op;
   logic [7:0] mr;
   // take without wait prefix
   assign tk = ready_q && instr_valid && !instr.wait_prefix;
   assign op = instr.opcode;
   assign mr = instr.modrm;
   // ----------------
   // assertions
   // ----------------
   a_status_mem: assert property (tk && op == 8'hDD && mr[7:6] != 2'h3 && mr[5:3] == 3'h7 |-> ##5 done_q)
      else $error("status store not done at 4");
   a_status_ax: assert property (tk && op == 8'hDF && mr == 8'hE0 |-> ##2 !done_q ##1 done_q)
      else $error("status to ax not done at 2");
   a_sub_range: assert property (tk && op inside {8'hD8, 8'hDC, 8'hDE} && mr[7:4] == 4'hE |-> ##[5:10] done_q)
      else $error("subtract outside 4 to 9");
   a_test_class: assert property (tk && op == 8'hD9 && (mr == 8'hE4 || mr == 8'hE5) |-> ##5 done_q)
      else $error("test or classify not done at 4");
   a_compare_time: assert property (tk && op == 8'hDD && mr[7:4] == 4'hE |-> ##5 done_q)
      else $error("compare not done at 4");
   a_pop_two: assert property (tk && op == 8'hDA && mr == 8'hE9 ##5 done_q |-> top_q == $past(top_q) + 3'h2)
      else $error("pop two wrong top");
   a_wait_idle: assert property (tk && op == 8'h9B && !unit_busy |=> !done_q ##1 !done_q ##1 done_q)
      else $error("wait not done at 2");
   a_swap_time: assert property (tk && op == 8'hD9 && mr[7:3] == 5'h19 |-> ##4 done_q)
      else $error("swap not done at 3");
   a_log_range: assert property (tk && op == 8'hD9 && mr == 8'hF1 |-> ##[146:155] done_q)
      else $error("log2 outside 145 to 154");
   a_top_still: assert property (!done_q |-> $stable(top_q))
      else $error("top moved without done");
endmodule
bind fsc_decoder fsc_decoder_checker u_chk (.core_clk(core_clk), .rstn(rstn), .instr_valid(instr_valid),
   .instr(instr), .unit_busy(unit_busy), .exec_done(exec_done), .ready_q(ready_q), .start_q(start_q),
   .ctrl_q(ctrl_q), .done_q(done_q), .bad_q(bad_q), .top_q(top_q));
`default_nettype wire

// file: bench/fsc_exec_model.sv
// Execution unit stand-in: busy window and finish pulse.
// Assumes start pulses from the decoder on core_clk.
`default_nettype none
module fsc_exec_model (
   // clock and reset
   input wire logic core_clk,
   input wire logic rstn,
   // from decoder and bench
   input wire logic start,
   input wire logic [7:0] lat,
   input wire logic busy_go,
   input wire logic [7:0] busy_len,
   // to decoder
   output logic exec_done,
   output logic unit_busy
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] c_q;
   logic [7:0] b_q;
   // cycles since start, saturating
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) c_q <= 8'h00;
      else if (start) c_q <= 8'h01;
      else if (c_q != 8'h00 && c_q != 8'hFF) c_q <= c_q + 8'h01;
   end
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) b_q <= 8'h00;
      else if (busy_go) b_q <= busy_len;
      else if (b_q != 8'h00) b_q <= b_q - 8'h01;
   end
   // lat zero: never finishes early
   assign exec_done = lat != 8'h00 && c_q == lat;
   assign unit_busy = b_q != 8'h00;
endmodule
`default_nettype wire

// file: bench/fsc_decoder_tb_top.sv
// Self-checking bench for fsc_decoder.
// Assumes fsc_exec_model stands in for the execution unit.
`default_nettype none
module fsc_decoder_tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   import fsc_pkg::*;
   logic core_clk, rstn, instr_valid, unit_busy, exec_done, ready_q, start_q, done_q, bad_q, busy_go;
   fsc_instr_t instr;
   fsc_ctrl_t ctrl_q;
   logic [2:0] top_q, exp_top, pre_top;
   logic [7:0] lat_v;
   int n_errors, n_compared, last_n;
   fsc_decoder dut (.core_clk(core_clk), .rstn(rstn), .instr_valid(instr_valid), .instr(instr),
      .unit_busy(unit_busy), .exec_done(exec_done), .ready_q(ready_q), .start_q(start_q), .ctrl_q(ctrl_q),
      .done_q(done_q), .bad_q(bad_q), .top_q(top_q));
   fsc_exec_model u_exec (.core_clk(core_clk), .rstn(rstn), .start(start_q), .lat(lat_v), .busy_go(busy_go),
      .busy_len(8'h0A), .exec_done(exec_done), .unit_busy(unit_busy));
   always #20 core_clk = ~core_clk;
   // ----------------
   // helpers
   // ----------------
   task automatic chk(input logic ok, input string m);
      n_compared++;
      if (ok !== 1'b1) begin
         n_errors++;
         $display("[FAIL] %0t %s", $time, m);
      end
   endtask
   // kx below zero skips the count check
   task automatic issue(input logic p, input logic [7:0] op, input logic [7:0] mr, input int lat, input int kx,
      input logic [2:0] dt, input logic bad);
      while (ready_q !== 1'b1) @(negedge core_clk);
      lat_v = lat[7:0];
      instr = {p, op, mr};
      instr_valid = 1'b1;
      @(posedge core_clk);
      @(negedge core_clk);
      instr_valid = 1'b0;
      chk(start_q === !bad && ready_q === 1'b0, "start or ready");
      // last_n is the done edge, the take edge being zero
      last_n = 0;
      while (done_q !== 1'b1 && bad_q !== 1'b1 && last_n < 300) begin
         @(negedge core_clk);
         last_n++;
      end
      pre_top = exp_top;
      exp_top = exp_top + dt;
      chk((kx < 0 || last_n == kx) && (bad ? bad_q : done_q) === 1'b1 && top_q === exp_top, "count or stack");
   endtask
   task automatic slots(input logic [2:0] a, input logic [2:0] b, input logic [2:0] d);
      chk(ctrl_q.a_phys === pre_top + a && ctrl_q.b_phys === pre_top + b && ctrl_q.dst_phys === pre_top + d, "slots");
   endtask
   // ----------------
   // scenarios
   // ----------------
   task automatic t_store;
      issue(0, 8'hDB, 8'h10, 0, 13, 0, 0);
      issue(0, 8'hDF, 8'h10, 7, 8, 0, 0);
      issue(0, 8'hDF, 8'h38, 10, 11, 1, 0);
      chk(ctrl_q.width === FSC_W_64 && ctrl_q.dst_mem === 1'b1 && ctrl_q.pops === 2'h1, "store width");
      issue(0, 8'hDB, 8'h18, 0, 13, 1, 0);
      issue(0, 8'hDF, 8'h18, 5, 10, 1, 0);
      issue(0, 8'hD9, 8'h38, 0, 3, 0, 0);
      issue(1, 8'hD9, 8'h38, 0, 5, 0, 0);
      issue(0, 8'hD9, 8'h30, 0, 22, 0, 0);
      issue(1, 8'hD9, 8'h30, 13, 14, 0, 0);
      issue(0, 8'hDD, 8'h38, 0, 4, 0, 0);
      issue(1, 8'hDD, 8'h38, 0, 6, 0, 0);
      issue(0, 8'hDF, 8'hE0, 0, 2, 0, 0);
      issue(1, 8'hDF, 8'hE0, 0, 4, 0, 0);
      $display("t_store done");
   endtask
   task automatic t_sub;
      issue(0, 8'hDC, 8'hE9, 4, 5, 0, 0);
      slots(1, 0, 1);
      issue(0, 8'hD8, 8'hE2, 0, 9, 0, 0);
      slots(0, 2, 0);
      issue(0, 8'hDC, 8'h20, 8, 9, 0, 0);
      chk(ctrl_q.width === FSC_W_64 && ctrl_q.b_mem === 1'b1 && ctrl_q.a_mem === 1'b0, "memory operand");
      issue(0, 8'hDE, 8'hE9, 0, 9, 1, 0);
      slots(1, 0, 1);
      issue(0, 8'hDC, 8'hE3, 5, 6, 0, 0);
      slots(3, 0, 0);
      issue(0, 8'hD8, 8'h28, 3, 4, 0, 0);
      issue(0, 8'hDE, 8'hE1, 6, 7, 1, 0);
      slots(0, 1, 1);
      issue(0, 8'hDA, 8'h20, 0, 29, 0, 0);
      issue(0, 8'hDE, 8'h20, 13, 14, 0, 0);
      issue(0, 8'hDA, 8'h28, 21, 22, 0, 0);
      chk(ctrl_q.a_mem === 1'b1 && ctrl_q.op === FSC_ISUB, "reverse operand");
      issue(0, 8'hDE, 8'h28, 0, 27, 0, 0);
      $display("t_sub done");
   endtask
   task automatic t_misc;
      issue(0, 8'hD9, 8'hE4, 0, 4, 0, 0);
      issue(0, 8'hDD, 8'hE2, 0, 4, 0, 0);
      issue(0, 8'hDD, 8'hEA, 0, 4, 1, 0);
      issue(0, 8'hDA, 8'hE9, 0, 4, 2, 0);
      issue(0, 8'h9B, 8'h00, 0, 2, 0, 0);
      issue(0, 8'hD9, 8'hE5, 0, 4, 0, 0);
      issue(0, 8'hD9, 8'hCB, 0, 3, 0, 0);
      issue(0, 8'hD9, 8'hF4, 0, 16, 7, 0);
      chk(ctrl_q.push === 1'b1 && ctrl_q.op === FSC_SPLIT, "split push");
      issue(0, 8'hD9, 8'hF1, 144, 145, 1, 0);
      issue(0, 8'hD9, 8'hF9, 0, 133, 1, 0);
      issue(0, 8'hD9, 8'hD0, 0, 0, 0, 1);
      $display("t_misc done");
   endtask
   task automatic t_wait;
      busy_go = 1'b1;
      @(negedge core_clk);
      busy_go = 1'b0;
      issue(0, 8'h9B, 8'h00, 0, -1, 0, 0);
      chk(last_n > 9 && last_n < 18, "wait did not stall");
      $display("t_wait done");
   endtask
   task automatic t_reset;
      instr = {1'b0, 8'hD9, 8'hF1};
      instr_valid = 1'b1;
      @(negedge core_clk);
      instr_valid = 1'b0;
      repeat (5) @(negedge core_clk);
      rstn = 1'b0;
      #1;
      chk(ready_q === 1'b1 && top_q === 3'h0 && done_q === 1'b0, "reset values");
      repeat (6) @(negedge core_clk);
      rstn = 1'b1;
      exp_top = 3'h0;
      $display("t_reset done");
   endtask
   task automatic final_report;
      $display("compared %0d errors %0d", n_compared, n_errors);
      if (n_errors == 0 && n_compared > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   initial begin
      #100us;
      n_errors++;
      final_report;
   end
   initial begin
      core_clk = 1'b0;
      rstn = 1'b0;
      instr_valid = 1'b0;
      instr = '0;
      busy_go = 1'b0;
      lat_v = 8'h00;
      exp_top = 3'h0;
      pre_top = 3'h0;
      n_errors = 0;
      n_compared = 0;
      repeat (6) @(negedge core_clk);
      rstn = 1'b1;
      t_store;
      t_sub;
      t_misc;
      t_wait;
      t_reset;
      issue(0, 8'hDD, 8'hEA, 0, 4, 1, 0);
      final_report;
   end
endmodule
`default_nettype wire
